// >>> inc/pcr_consts.vh
// Purpose: constants for the multiplier and input path configuration bank
// Assumes: 16-bit registers, one aligned 32-bit word each on the bus
// Notes: offsets are register indices; byte address is four times the index
`ifndef PCR_CONSTS_VH
`define PCR_CONSTS_VH

// ----------------------------------------
// register indices
// ----------------------------------------
`define PCR_IDX_W 6
`define PCR_IDX_PLL_CONTROL 6'h24
`define PCR_IDX_FRAC_UPPER 6'h25
`define PCR_IDX_FRAC_MIDDLE 6'h26
`define PCR_IDX_FRAC_LOWER 6'h27
`define PCR_IDX_RESERVED_A 6'h28
`define PCR_IDX_RESERVED_B 6'h29
`define PCR_IDX_ZERO_CROSS 6'h2A
`define PCR_IDX_RESERVED_C 6'h2B
`define PCR_IDX_INPUT_SRC 6'h2C
`define PCR_IDX_STATUS 6'h3F

// ----------------------------------------
// writable bit masks
// ----------------------------------------
`define PCR_MASK_PLL_CONTROL 16'h00FF
`define PCR_MASK_FRAC_UPPER 16'h003F
`define PCR_MASK_FRAC_NINE 16'h01FF
`define PCR_MASK_ZERO_CROSS 16'h0002
`define PCR_MASK_INPUT_SRC 16'h010F

// ----------------------------------------
// reset values
// ----------------------------------------
`define PCR_RST_PLL_CONTROL 16'h004C
`define PCR_RST_FRAC_UPPER 16'h000C
`define PCR_RST_FRAC_MIDDLE 16'h0093
`define PCR_RST_FRAC_LOWER 16'h00E9
`define PCR_RST_ZERO_CROSS 16'h0000
`define PCR_RST_INPUT_SRC 16'h0002

// ----------------------------------------
// field positions
// ----------------------------------------
`define PCR_BIT_POWER_OFF 7
`define PCR_BIT_FRAC_ON 6
`define PCR_PRESCALE_HI 5
`define PCR_PRESCALE_LO 4
`define PCR_INT_HI 3
`define PCR_INT_LO 0
`define PCR_BIT_ZERO_CROSS 1
`define PCR_BIT_MIC_BIAS 8
`define PCR_BIT_AUX_MODE 3
`define PCR_BIT_AUX_NEG 2
`define PCR_BIT_MIC_NEG 1
`define PCR_BIT_MIC_POS 0

// ----------------------------------------
// codes and limits
// ----------------------------------------
`define PCR_PRE_X2 2'h0
`define PCR_PRE_X1 2'h1
`define PCR_PRE_DIV2 2'h2
`define PCR_PRE_DIV4 2'h3
`define PCR_INT_MIN_EXCL 4'h5
`define PCR_INT_MAX_EXCL 4'hD
`define PCR_HTRANS_NONSEQ 2'h2
`define PCR_HSIZE_WORD 3'h2

`endif

// >>> hw/pcr_field_reg.v
// Purpose: one configuration register with a mask of writable bits
// Assumes: synchronous active-high reset
// Notes: next_q is exported so readback can see a write in flight
`default_nettype none

module pcr_field_reg #(
  parameter [15:0] RESET = 16'h0000,
  parameter [15:0] MASK = 16'hFFFF
) (
  input wire clk, // system clock
  input wire srst, // synchronous reset
  input wire we, // write strobe
  input wire [15:0] wdata, // write data
  output reg [15:0] q, // stored value
  output reg [15:0] next_q // value after this edge
);

  always @* begin
    next_q = q;
    if (we) begin
      next_q = wdata & MASK;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      q <= RESET & MASK;
    end else begin
      q <= next_q;
    end
  end

endmodule // pcr_field_reg

`default_nettype wire

// >>> hw/pcr_ahb_slave.v
// Purpose: AHB-Lite slave front end, zero wait states, always OKAY
// Assumes: single word transfers; other sizes are not written
// Notes: read data is captured at the address-phase edge from rd_word
`default_nettype none
`include "pcr_consts.vh"

module pcr_ahb_slave #(
  parameter ADDR_W = 8
) (
  input wire clk, // system clock
  input wire srst, // synchronous reset
  input wire hsel, // slave select
  input wire [ADDR_W-1:0] haddr, // byte address
  input wire [1:0] htrans, // transfer type
  input wire hwrite, // write not read
  input wire [2:0] hsize, // transfer size
  input wire [31:0] hwdata, // write data
  input wire hready, // bus ready
  input wire [15:0] rd_word, // register at rd_idx
  output wire [`PCR_IDX_W-1:0] rd_idx, // index in address phase
  output wire wr_en, // write in data phase
  output wire [15:0] wr_data, // low half of write data
  output reg [`PCR_IDX_W-1:0] wr_idx, // index of pending write
  output reg [31:0] hrdata, // read data
  output reg hreadyout, // never stalls
  output reg hresp // always OKAY
);

  reg wr_pend;
  wire take;

  assign take = hsel & hready & (htrans == `PCR_HTRANS_NONSEQ);
  assign rd_idx = haddr[ADDR_W-1:2];
  assign wr_en = wr_pend;
  assign wr_data = hwdata[15:0];

  always @(posedge clk) begin
    if (srst) begin
      wr_pend <= 1'b0;
      wr_idx <= {`PCR_IDX_W{1'b0}};
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (hready) begin
        wr_pend <= take & hwrite & (hsize == `PCR_HSIZE_WORD);
        wr_idx <= rd_idx;
      end
      if (take & ~hwrite) begin
        hrdata <= {16'h0000, rd_word};
      end
    end
  end

endmodule // pcr_ahb_slave

`default_nettype wire

// >>> hw/pcr_regs_top.v
// Purpose: multiplier and analogue input path configuration register bank
// Assumes: AHB-Lite master, word accesses, one clock CLK_SYS at 20 MHz
// Notes: all control outputs are static levels straight from flip-flops
//   readback shows the value a register takes at the current edge
`default_nettype none
`include "pcr_consts.vh"

module pcr_regs_top #(
  parameter ADDR_W = 8
) (
  input wire CLK_SYS, // system clock
  input wire SRST, // synchronous reset, active high
  input wire HSEL, // AHB slave select
  input wire [ADDR_W-1:0] HADDR, // AHB byte address
  input wire [1:0] HTRANS, // AHB transfer type
  input wire HWRITE, // AHB write not read
  input wire [2:0] HSIZE, // AHB transfer size
  input wire [31:0] HWDATA, // AHB write data
  input wire HREADY, // AHB bus ready
  output wire [31:0] HRDATA, // AHB read data
  output wire HREADYOUT, // AHB slave ready
  output wire HRESP, // AHB response
  output wire MULTIPLIER_POWER_OFF, // multiplier powered off
  output wire FRACTIONAL_DIVIDE_ON, // fractional divide enabled
  output wire [1:0] MULTIPLIER_INPUT_PRESCALE, // raw prescale code
  output reg PRESCALE_X2, // master clock doubled
  output reg PRESCALE_X1, // master clock passed through
  output reg PRESCALE_DIV2, // master clock halved
  output reg PRESCALE_DIV4, // master clock quartered
  output wire [3:0] RATIO_INTEGER_PART, // integer ratio
  output reg [23:0] RATIO_FRACTION_PART, // joined fractional ratio
  output reg RATIO_INTEGER_BAD, // integer ratio outside 6..12
  output wire LEVEL_CTRL_ZERO_CROSS_ON, // level control zero-cross
  output wire MIC_BIAS_LEVEL_SELECT, // 0: 0.9, 1: 0.75 of supply
  output wire AUX_INPUT_CONFIG, // 0: inverting buffer, 1: mixer
  output wire AUX_TO_AMP_NEG_SELECT, // aux to amplifier negative
  output wire MIC_NEG_TO_AMP_SELECT, // negative mic pin to amplifier
  output wire MIC_POS_TO_AMP_SELECT // positive terminal source
);

  // ----------------------------------------
  // functions
  // ----------------------------------------

  // one-hot prescale decode, bit order x2, x1, div2, div4
  function [3:0] prescale_onehot;
    input [1:0] code;
    begin
      case (code)
        `PCR_PRE_X2: prescale_onehot = 4'h8;
        `PCR_PRE_X1: prescale_onehot = 4'h4;
        `PCR_PRE_DIV2: prescale_onehot = 4'h2;
        `PCR_PRE_DIV4: prescale_onehot = 4'h1;
        default: prescale_onehot = 4'h0;
      endcase
    end
  endfunction

  // integer ratio outside the usable band
  function int_ratio_bad;
    input [3:0] n;
    begin
      int_ratio_bad = (n <= `PCR_INT_MIN_EXCL) || (n >= `PCR_INT_MAX_EXCL);
    end
  endfunction

  // join the three fraction fields, upper first
  function [23:0] frac_join;
    input [15:0] upper;
    input [15:0] middle;
    input [15:0] lower;
    begin
      frac_join = {upper[5:0], middle[8:0], lower[8:0]};
    end
  endfunction

  // write strobe of one register index during the data phase
  function idx_strobe;
    input en;
    input [`PCR_IDX_W-1:0] idx;
    input [`PCR_IDX_W-1:0] target;
    begin
      idx_strobe = en & (idx == target);
    end
  endfunction

  // ----------------------------------------
  // reset images
  // ----------------------------------------

  // masked first: a plain join of the 16-bit constants would keep the wrong bits
  // once the 48-bit result is cut down to the 24-bit ratio
  localparam [15:0] RST_UPPER = `PCR_RST_FRAC_UPPER & `PCR_MASK_FRAC_UPPER;
  localparam [15:0] RST_MIDDLE = `PCR_RST_FRAC_MIDDLE & `PCR_MASK_FRAC_NINE;
  localparam [15:0] RST_LOWER = `PCR_RST_FRAC_LOWER & `PCR_MASK_FRAC_NINE;

  // ----------------------------------------
  // bus front end
  // ----------------------------------------

  wire [`PCR_IDX_W-1:0] rd_idx;
  wire [`PCR_IDX_W-1:0] wr_idx;
  wire wr_en;
  wire [15:0] wr_data;
  reg [15:0] rd_word;

  // the slave never inserts wait states, so every transfer completes in two edges;
  // a write lands at the end of its data phase, one edge after the address is taken
  pcr_ahb_slave #(
    .ADDR_W(ADDR_W)
  ) u_bus (
    .clk(CLK_SYS),
    .srst(SRST),
    .hsel(HSEL),
    .haddr(HADDR),
    .htrans(HTRANS),
    .hwrite(HWRITE),
    .hsize(HSIZE),
    .hwdata(HWDATA),
    .hready(HREADY),
    .rd_word(rd_word),
    .rd_idx(rd_idx),
    .wr_en(wr_en),
    .wr_data(wr_data),
    .wr_idx(wr_idx),
    .hrdata(HRDATA),
    .hreadyout(HREADYOUT),
    .hresp(HRESP)
  );

  // ----------------------------------------
  // write strobes
  // ----------------------------------------

  wire we_ctrl;
  wire we_upper;
  wire we_middle;
  wire we_lower;
  wire we_zc;
  wire we_src;

  assign we_ctrl = idx_strobe(wr_en, wr_idx, `PCR_IDX_PLL_CONTROL);
  assign we_upper = idx_strobe(wr_en, wr_idx, `PCR_IDX_FRAC_UPPER);
  assign we_middle = idx_strobe(wr_en, wr_idx, `PCR_IDX_FRAC_MIDDLE);
  assign we_lower = idx_strobe(wr_en, wr_idx, `PCR_IDX_FRAC_LOWER);
  assign we_zc = idx_strobe(wr_en, wr_idx, `PCR_IDX_ZERO_CROSS);
  assign we_src = idx_strobe(wr_en, wr_idx, `PCR_IDX_INPUT_SRC);

  // ----------------------------------------
  // register storage
  // ----------------------------------------

  wire [15:0] ctrl_q;
  wire [15:0] ctrl_next;
  wire [15:0] upper_q;
  wire [15:0] upper_next;
  wire [15:0] middle_q;
  wire [15:0] middle_next;
  wire [15:0] lower_q;
  wire [15:0] lower_next;
  wire [15:0] zc_q;
  wire [15:0] zc_next;
  wire [15:0] src_q;
  wire [15:0] src_next;

  pcr_field_reg #(
    .RESET(`PCR_RST_PLL_CONTROL),
    .MASK(`PCR_MASK_PLL_CONTROL)
  ) u_ctrl (
    .clk(CLK_SYS),
    .srst(SRST),
    .we(we_ctrl),
    .wdata(wr_data),
    .q(ctrl_q),
    .next_q(ctrl_next)
  );

  pcr_field_reg #(
    .RESET(`PCR_RST_FRAC_UPPER),
    .MASK(`PCR_MASK_FRAC_UPPER)
  ) u_upper (
    .clk(CLK_SYS),
    .srst(SRST),
    .we(we_upper),
    .wdata(wr_data),
    .q(upper_q),
    .next_q(upper_next)
  );

  pcr_field_reg #(
    .RESET(`PCR_RST_FRAC_MIDDLE),
    .MASK(`PCR_MASK_FRAC_NINE)
  ) u_middle (
    .clk(CLK_SYS),
    .srst(SRST),
    .we(we_middle),
    .wdata(wr_data),
    .q(middle_q),
    .next_q(middle_next)
  );

  pcr_field_reg #(
    .RESET(`PCR_RST_FRAC_LOWER),
    .MASK(`PCR_MASK_FRAC_NINE)
  ) u_lower (
    .clk(CLK_SYS),
    .srst(SRST),
    .we(we_lower),
    .wdata(wr_data),
    .q(lower_q),
    .next_q(lower_next)
  );

  pcr_field_reg #(
    .RESET(`PCR_RST_ZERO_CROSS),
    .MASK(`PCR_MASK_ZERO_CROSS)
  ) u_zc (
    .clk(CLK_SYS),
    .srst(SRST),
    .we(we_zc),
    .wdata(wr_data),
    .q(zc_q),
    .next_q(zc_next)
  );

  pcr_field_reg #(
    .RESET(`PCR_RST_INPUT_SRC),
    .MASK(`PCR_MASK_INPUT_SRC)
  ) u_src (
    .clk(CLK_SYS),
    .srst(SRST),
    .we(we_src),
    .wdata(wr_data),
    .q(src_q),
    .next_q(src_next)
  );

  // ----------------------------------------
  // multiplier controls
  // ----------------------------------------

  assign MULTIPLIER_POWER_OFF = ctrl_q[`PCR_BIT_POWER_OFF];
  assign FRACTIONAL_DIVIDE_ON = ctrl_q[`PCR_BIT_FRAC_ON];
  assign MULTIPLIER_INPUT_PRESCALE = ctrl_q[`PCR_PRESCALE_HI:`PCR_PRESCALE_LO];
  assign RATIO_INTEGER_PART = ctrl_q[`PCR_INT_HI:`PCR_INT_LO];

  // decode from next values so the flags move on the same edge as the field
  wire [3:0] next_prescale;
  wire [23:0] next_fraction;
  wire next_int_bad;

  assign next_prescale = prescale_onehot(ctrl_next[`PCR_PRESCALE_HI:`PCR_PRESCALE_LO]);
  assign next_fraction = frac_join(upper_next, middle_next, lower_next);
  // the integer ratio is not clamped: an illegal value is stored and flagged,
  // so software reads back exactly what it wrote
  // flag illegal integer ratio
  assign next_int_bad = int_ratio_bad(ctrl_next[`PCR_INT_HI:`PCR_INT_LO]);

  // ----------------------------------------
  // decoded output flops
  // ----------------------------------------

  always @(posedge CLK_SYS) begin
    if (SRST) begin
      PRESCALE_X2 <= 1'b1;
      PRESCALE_X1 <= 1'b0;
      PRESCALE_DIV2 <= 1'b0;
      PRESCALE_DIV4 <= 1'b0;
      RATIO_FRACTION_PART <= frac_join(RST_UPPER, RST_MIDDLE, RST_LOWER);
      RATIO_INTEGER_BAD <= 1'b0;
    end else begin
      PRESCALE_X2 <= next_prescale[3];
      PRESCALE_X1 <= next_prescale[2];
      PRESCALE_DIV2 <= next_prescale[1];
      PRESCALE_DIV4 <= next_prescale[0];
      RATIO_FRACTION_PART <= next_fraction;
      RATIO_INTEGER_BAD <= next_int_bad;
    end
  end

  // ----------------------------------------
  // input path controls
  // ----------------------------------------

  assign LEVEL_CTRL_ZERO_CROSS_ON = zc_q[`PCR_BIT_ZERO_CROSS];
  assign MIC_BIAS_LEVEL_SELECT = src_q[`PCR_BIT_MIC_BIAS];
  assign AUX_INPUT_CONFIG = src_q[`PCR_BIT_AUX_MODE];
  assign AUX_TO_AMP_NEG_SELECT = src_q[`PCR_BIT_AUX_NEG];
  assign MIC_NEG_TO_AMP_SELECT = src_q[`PCR_BIT_MIC_NEG];
  assign MIC_POS_TO_AMP_SELECT = src_q[`PCR_BIT_MIC_POS];

  // ----------------------------------------
  // status and readback
  // ----------------------------------------

  wire [15:0] status_word;
  wire next_frac_running;

  // fraction divide only matters while the multiplier is powered
  assign next_frac_running = ctrl_next[`PCR_BIT_FRAC_ON] & ~ctrl_next[`PCR_BIT_POWER_OFF];
  // state seen by the multiplier after this edge; status is read-only
  assign status_word = {14'h0000,
                        next_frac_running,
                        next_int_bad};

  // next values are read so a read right behind a write sees the new data:
  // the read is captured on the very edge at which that write lands, so the
  // stored values would still be one write stale
  always @* begin
    case (rd_idx)
      `PCR_IDX_PLL_CONTROL: rd_word = ctrl_next;
      `PCR_IDX_FRAC_UPPER: rd_word = upper_next;
      `PCR_IDX_FRAC_MIDDLE: rd_word = middle_next;
      `PCR_IDX_FRAC_LOWER: rd_word = lower_next;
      `PCR_IDX_ZERO_CROSS: rd_word = zc_next;
      `PCR_IDX_INPUT_SRC: rd_word = src_next;
      `PCR_IDX_STATUS: rd_word = status_word;
      `PCR_IDX_RESERVED_A, `PCR_IDX_RESERVED_B, `PCR_IDX_RESERVED_C: rd_word = 16'h0000;
      default: rd_word = 16'h0000;
    endcase
  end

endmodule // pcr_regs_top

`default_nettype wire

// >>> tb/pcr_regs_top_assertions.sv
// Purpose: bus-to-output checks for the config register bank
// Assumes: zero wait state slave, word writes land at the data-phase edge
// Notes: sees only the top module ports
`default_nettype none

module pcr_regs_top_chk #(
  parameter ADDR_W = 8
) (
  input wire logic CLK_SYS, // clock
  input wire logic SRST, // sync reset
  input wire logic HSEL, // select
  input wire logic [ADDR_W-1:0] HADDR, // byte address
  input wire logic [1:0] HTRANS, // transfer type
  input wire logic HWRITE, // write
  input wire logic [2:0] HSIZE, // size
  input wire logic [31:0] HWDATA, // write data
  input wire logic HREADY, // bus ready
  input wire logic [31:0] HRDATA, // read data
  input wire logic FRACTIONAL_DIVIDE_ON, // fraction on
  input wire logic [1:0] MULTIPLIER_INPUT_PRESCALE, // prescale code
  input wire logic PRESCALE_X2, // x2
  input wire logic PRESCALE_X1, // x1
  input wire logic PRESCALE_DIV2, // div2
  input wire logic PRESCALE_DIV4, // div4
  input wire logic [3:0] RATIO_INTEGER_PART, // integer ratio
  input wire logic [23:0] RATIO_FRACTION_PART, // fraction ratio
  input wire logic RATIO_INTEGER_BAD, // illegal integer
  input wire logic LEVEL_CTRL_ZERO_CROSS_ON, // zero cross
  input wire logic MIC_BIAS_LEVEL_SELECT, // bias level
  input wire logic AUX_INPUT_CONFIG, // aux mode
  input wire logic AUX_TO_AMP_NEG_SELECT, // aux to amp
  input wire logic MIC_NEG_TO_AMP_SELECT, // mic neg to amp
  input wire logic MIC_POS_TO_AMP_SELECT // mic pos source
);
  // ----------------------------------------
  // data phase tracking
  // ----------------------------------------
  logic wr_d;
  logic rd_d;
  logic [ADDR_W-3:0] idx_d;
  wire take = HSEL && HREADY && HTRANS == 2'h2;

  // only word writes are stored, so narrow ones must not count as writes
  always @(posedge CLK_SYS) begin
    if (SRST) begin
      wr_d <= 1'b0;
      rd_d <= 1'b0;
    end else begin
      wr_d <= take && HWRITE && HSIZE == 3'h2;
      rd_d <= take && !HWRITE;
    end
    idx_d <= HADDR[ADDR_W-1:2];
  end

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SRST);

  // ----------------------------------------
  // properties
  // ----------------------------------------
  property p_frac_on;
    wr_d && idx_d == 6'h24 |=> FRACTIONAL_DIVIDE_ON == $past(HWDATA[6]);
  endproperty
  a_frac_on: assert property (p_frac_on) else $error("fraction enable not written");
  property p_prescale;
    {PRESCALE_X2, PRESCALE_X1, PRESCALE_DIV2, PRESCALE_DIV4} == 4'h8 >> MULTIPLIER_INPUT_PRESCALE;
  endproperty
  a_prescale: assert property (p_prescale) else $error("prescale decode wrong");
  property p_bad;
    RATIO_INTEGER_BAD == (RATIO_INTEGER_PART < 4'h6 || RATIO_INTEGER_PART > 4'hC);
  endproperty
  a_bad: assert property (p_bad) else $error("integer flag wrong");
  property p_frac_up;
    wr_d && idx_d == 6'h25 |=> RATIO_FRACTION_PART[23:18] == $past(HWDATA[5:0]);
  endproperty
  a_frac_up: assert property (p_frac_up) else $error("fraction upper not joined");
  property p_frac_hold;
    !(wr_d && idx_d inside {6'h25, 6'h26, 6'h27}) |=> $stable(RATIO_FRACTION_PART);
  endproperty
  a_frac_hold: assert property (p_frac_hold) else $error("fraction moved");
  property p_reset;
    disable iff (1'b0)
    SRST |=> FRACTIONAL_DIVIDE_ON && MIC_NEG_TO_AMP_SELECT && RATIO_FRACTION_PART == 24'h3126E9;
  endproperty
  a_reset: assert property (p_reset) else $error("reset values wrong");
  property p_zero_cross;
    wr_d && idx_d == 6'h2A |=> LEVEL_CTRL_ZERO_CROSS_ON == $past(HWDATA[1]);
  endproperty
  a_zero_cross: assert property (p_zero_cross) else $error("zero cross not written");
  property p_src;
    wr_d && idx_d == 6'h2C |=> MIC_BIAS_LEVEL_SELECT == $past(HWDATA[8]) && {AUX_INPUT_CONFIG,
      AUX_TO_AMP_NEG_SELECT, MIC_NEG_TO_AMP_SELECT, MIC_POS_TO_AMP_SELECT} == $past(HWDATA[3:0]);
  endproperty
  a_src: assert property (p_src) else $error("input source not written");
  property p_rsvd;
    rd_d && idx_d inside {6'h28, 6'h29, 6'h2B, 6'h30} |-> HRDATA == 32'h0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved read not zero");
endmodule // pcr_regs_top_chk

bind pcr_regs_top pcr_regs_top_chk #(.ADDR_W(ADDR_W)) chk_u (
  .CLK_SYS(CLK_SYS), .SRST(SRST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
  .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
  .FRACTIONAL_DIVIDE_ON(FRACTIONAL_DIVIDE_ON),
  .MULTIPLIER_INPUT_PRESCALE(MULTIPLIER_INPUT_PRESCALE), .PRESCALE_X2(PRESCALE_X2),
  .PRESCALE_X1(PRESCALE_X1), .PRESCALE_DIV2(PRESCALE_DIV2), .PRESCALE_DIV4(PRESCALE_DIV4),
  .RATIO_INTEGER_PART(RATIO_INTEGER_PART), .RATIO_FRACTION_PART(RATIO_FRACTION_PART),
  .RATIO_INTEGER_BAD(RATIO_INTEGER_BAD), .LEVEL_CTRL_ZERO_CROSS_ON(LEVEL_CTRL_ZERO_CROSS_ON),
  .MIC_BIAS_LEVEL_SELECT(MIC_BIAS_LEVEL_SELECT), .AUX_INPUT_CONFIG(AUX_INPUT_CONFIG),
  .AUX_TO_AMP_NEG_SELECT(AUX_TO_AMP_NEG_SELECT), .MIC_NEG_TO_AMP_SELECT(MIC_NEG_TO_AMP_SELECT),
  .MIC_POS_TO_AMP_SELECT(MIC_POS_TO_AMP_SELECT)
);

`default_nettype wire

// >>> tb/pcr_regs_top_test.sv
// Purpose: self-checking bench for the config register bank
// Assumes: one master; slave ready is fed back as bus ready
// Notes: each row writes, reads back and views the driven outputs
`default_nettype none

module pcr_regs_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [5:0] idx;
    logic [31:0] wd;
    logic [15:0] rd;
    logic [23:0] vw;
  } pcr_row_t;
  logic CLK_SYS = 1'b0;
  logic SRST = 1'b1;
  logic HSEL = 1'b0;
  logic HWRITE = 1'b0;
  logic [7:0] HADDR = 8'h00;
  logic [1:0] HTRANS = 2'h0;
  logic [2:0] HSIZE = 3'h2;
  logic [31:0] HWDATA = 32'h0;
  wire [31:0] HRDATA;
  wire HREADYOUT, HRESP, pwr_off, frac_on, x2, x1, d2, d4, bad, zc;
  wire bias, aux_cfg, aux_neg, mic_neg, mic_pos;
  wire [1:0] pre;
  wire [3:0] int_part;
  wire [23:0] frac;
  wire HREADY = HREADYOUT;
  int mismatches = 0;
  int tests_run = 0;
  int cycles = 0;
  logic [15:0] rst_val [0:8] = '{16'h004C, 16'h000C, 16'h0093, 16'h00E9, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0002};
  pcr_row_t rows [0:16] = '{
    '{6'h24, 32'hFFFFFF06, 16'h0006, 24'h000806}, '{6'h24, 32'h0000005D, 16'h005D, 24'h00145D},
    '{6'h3F, 32'h0000FFFF, 16'h0003, 24'h000000}, '{6'h24, 32'h000000AC, 16'h00AC, 24'h0002AC},
    '{6'h24, 32'h00000035, 16'h0035, 24'h001135}, '{6'h3F, 32'h00000000, 16'h0001, 24'h000000},
    '{6'h25, 32'h0000FFFF, 16'h003F, 24'hFD26E9}, '{6'h26, 32'h00000155, 16'h0155, 24'hFEAAE9},
    '{6'h27, 32'h0000FEAA, 16'h00AA, 24'hFEAAAA}, '{6'h2A, 32'h0000FFFF, 16'h0002, 24'h000002},
    '{6'h2A, 32'h0000FFFD, 16'h0000, 24'h000000}, '{6'h2C, 32'h0000FFFF, 16'h010F, 24'h00010F},
    '{6'h2C, 32'h0000000A, 16'h000A, 24'h00000A}, '{6'h28, 32'hFFFFFFFF, 16'h0000, 24'h000000},
    '{6'h29, 32'hFFFFFFFF, 16'h0000, 24'h000000}, '{6'h2B, 32'h0000FFFF, 16'h0000, 24'h000000},
    '{6'h30, 32'h0000FFFF, 16'h0000, 24'h000000}};

  pcr_regs_top #(.ADDR_W(8)) dut_u (
    .CLK_SYS(CLK_SYS), .SRST(SRST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .MULTIPLIER_POWER_OFF(pwr_off),
    .FRACTIONAL_DIVIDE_ON(frac_on), .MULTIPLIER_INPUT_PRESCALE(pre), .PRESCALE_X2(x2),
    .PRESCALE_X1(x1), .PRESCALE_DIV2(d2), .PRESCALE_DIV4(d4), .RATIO_INTEGER_PART(int_part),
    .RATIO_FRACTION_PART(frac), .RATIO_INTEGER_BAD(bad), .LEVEL_CTRL_ZERO_CROSS_ON(zc),
    .MIC_BIAS_LEVEL_SELECT(bias), .AUX_INPUT_CONFIG(aux_cfg), .AUX_TO_AMP_NEG_SELECT(aux_neg),
    .MIC_NEG_TO_AMP_SELECT(mic_neg), .MIC_POS_TO_AMP_SELECT(mic_pos)
  );

  initial begin
    forever #25 CLK_SYS = ~CLK_SYS;
  end

  // outputs belonging to one register, packed in its own bit order
  function automatic logic [23:0] view(input logic [5:0] idx);
    case (idx)
      6'h24: view = {11'h0, bad, x2, x1, d2, d4, pwr_off, frac_on, pre, int_part};
      6'h25, 6'h26, 6'h27: view = frac;
      6'h2A: view = {22'h0, zc, 1'b0};
      6'h2C: view = {15'h0, bias, 4'h0, aux_cfg, aux_neg, mic_neg, mic_pos};
      default: view = 24'h0;
    endcase
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // single transfer; read data is taken at the data-phase edge
  task automatic xfer(input logic wr, input logic [5:0] idx, input logic [31:0] wd,
    input logic [2:0] sz, output logic [31:0] rd);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HADDR <= {idx, 2'h0};
    HWRITE <= wr;
    HSIZE <= sz;
    @(posedge CLK_SYS);
    while (HREADY !== 1'b1) @(posedge CLK_SYS);
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= wd;
    @(posedge CLK_SYS);
    while (HREADY !== 1'b1) @(posedge CLK_SYS);
    rd = HRDATA;
  endtask

  task automatic final_report;
    $display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // a hang counts as a mismatch
  always @(posedge CLK_SYS) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      mismatches++;
      final_report();
    end
  end

  initial begin
    logic [31:0] rd;
    repeat (8) @(posedge CLK_SYS);
    SRST <= 1'b0;
    @(posedge CLK_SYS);
    foreach (rows[i]) begin
      xfer(1'b1, rows[i].idx, rows[i].wd, 3'h2, rd);
      xfer(1'b0, rows[i].idx, 32'h0, 3'h2, rd);
      check(rd, {16'h0, rows[i].rd});
      check({8'h0, view(rows[i].idx)}, {8'h0, rows[i].vw});
      check({31'h0, HRESP}, 32'h0);
    end
    $display("table tests done");
    xfer(1'b1, 6'h2A, 32'h2, 3'h2, rd);
    xfer(1'b1, 6'h2A, 32'h0, 3'h0, rd);
    xfer(1'b0, 6'h2A, 32'h0, 3'h2, rd);
    check(rd, 32'h2);
    check({31'h0, zc}, 32'h1);
    $display("narrow write test done");
    SRST <= 1'b1;
    repeat (8) @(posedge CLK_SYS);
    SRST <= 1'b0;
    @(posedge CLK_SYS);
    for (int i = 0; i < 9; i++) begin
      xfer(1'b0, 6'h24 + i[5:0], 32'h0, 3'h2, rd);
      check(rd, {16'h0, rst_val[i]});
    end
    check({8'h0, view(6'h25)}, 32'h3126E9);
    check({8'h0, view(6'h24)}, 32'h084C);
    check({8'h0, view(6'h2C)}, 32'h0002);
    $display("second reset test done");
    final_report();
  end
endmodule // pcr_regs_top_test

`default_nettype wire
